// ### core/sdl_link.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ns
`include "sdl_regs.svh"

module sdl_link
    import sdl_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // serializer parallel side
    input  wire logic        transmit_word_clock,
    input  wire logic        transmit_edge_select,
    input  wire logic [9:0]  tx_word_in,
    input  wire logic        training_request_a,
    input  wire logic        training_request_b,
    input  wire logic        serial_drive_enable,
    input  wire logic        tx_sleep_request_n,
    // serializer serial side
    output logic             serial_out_pos,
    output logic             serial_out_neg,
    output logic             serial_out_oe,
    // deserializer serial side
    input  wire logic        serial_in_pos,
    input  wire logic        serial_in_neg,
    input  wire logic        receiver_reference_clock,
    // deserializer parallel side
    input  wire logic        recovered_edge_select,
    input  wire logic        parallel_output_enable,
    input  wire logic        rx_sleep_request_n,
    output logic [9:0]       parallel_word_out,
    output logic             parallel_word_oe,
    output logic             recovered_clock,
    output logic             recovered_clock_oe,
    output logic             lock_n,
    output logic             lock_oe,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             irq
);

    sdl_state_s st;
    sdl_state_s next_st;

    logic       capture;
    logic       train_req;
    logic       rx_bit;
    logic       ref_ok;
    logic       frame_done;
    logic       frame_good;
    logic       frame_bad;
    logic [2:0] events;
    logic       base_high;

    always_comb
    begin
        next_st = st;
        events  = 3'h0;

        capture = transmit_edge_select
                ? (transmit_word_clock & ~st.transmit_word_clock_prev)
                : (~transmit_word_clock & st.transmit_word_clock_prev);
        train_req = training_request_a | training_request_b;
        rx_bit    = serial_in_pos & ~serial_in_neg;
        ref_ok    = (st.ref_idle != `SDL_REF_LIMIT);

        next_st.transmit_word_clock_prev = transmit_word_clock;

        // serial shifter runs one bit per clock; line rests low
        if (st.tx_bits != 4'h0)
        begin
            next_st.tx_shreg = {st.tx_shreg[10:0], 1'b0};
            next_st.tx_bits  = st.tx_bits - 4'h1;
        end

        if (train_req && !st.train_act)
        begin
            next_st.train_act = 1'b1;
            next_st.train_cnt = 11'h0;
        end

        if (capture)
        begin
            next_st.tx_shreg = {1'b1,
                                st.train_act ? `SDL_SYNC_WORD : tx_word_in,
                                1'b0};
            next_st.tx_bits  = `SDL_FRAME_BITS;
            // count stops at the minimum so a long hold cannot wrap
            if (st.train_act && st.train_cnt != `SDL_TRAIN_MIN)
                next_st.train_cnt = st.train_cnt + 11'h1;
        end

        if (st.train_act && st.train_cnt == `SDL_TRAIN_MIN && !train_req)
        begin
            next_st.train_act = 1'b0;
            events[`SDL_EV_TRAIN_DONE] = 1'b1;
        end

        if (!tx_sleep_request_n)
        begin
            next_st.tx_shreg  = 12'h0;
            next_st.tx_bits   = 4'h0;
            next_st.train_act = 1'b0;
            next_st.train_cnt = 11'h0;
        end

        // reference clock activity watch
        next_st.ref_prev = receiver_reference_clock;
        if (receiver_reference_clock != st.ref_prev)
            next_st.ref_idle = 5'h0;
        else if (st.ref_idle != `SDL_REF_LIMIT)
            next_st.ref_idle = st.ref_idle + 5'h1;

        // frame receiver: start bit, ten data bits, stop bit
        frame_done = 1'b0;
        frame_good = 1'b0;
        frame_bad  = 1'b0;
        unique case (st.rx_state)
            SDL_RX_IDLE:
            begin
                if (rx_bit)
                begin
                    next_st.rx_state = SDL_RX_BITS;
                    next_st.rx_cnt   = 4'h0;
                    next_st.rx_wait  = 5'h0;
                end
                else if (st.rx_wait == `SDL_IDLE_LIMIT)
                begin
                    // a silent line counts as a frame without clock bits
                    frame_bad       = 1'b1;
                    next_st.rx_wait = 5'h0;
                end
                else
                    next_st.rx_wait = st.rx_wait + 5'h1;
            end
            SDL_RX_BITS:
            begin
                next_st.rx_shreg = {st.rx_shreg[9:0], rx_bit};
                next_st.rx_cnt   = st.rx_cnt + 4'h1;
                if (st.rx_cnt == `SDL_FRAME_BITS - 4'h2)
                begin
                    frame_done       = 1'b1;
                    next_st.rx_state = SDL_RX_IDLE;
                    next_st.rx_wait  = 5'h0;
                end
            end
        endcase
        if (frame_done)
        begin
            frame_good = ~rx_bit;
            frame_bad  = rx_bit;
        end

        if (frame_good)
        begin
            next_st.bad_cnt = 3'h0;
            if (!st.locked && ref_ok)
            begin
                next_st.good_cnt = st.good_cnt + 3'h1;
                if (st.good_cnt == `SDL_ACQ_FRAMES - 3'h1)
                begin
                    next_st.locked   = 1'b1;
                    next_st.good_cnt = 3'h0;
                    events[`SDL_EV_LOCK] = 1'b1;
                end
            end
            if (st.locked || st.good_cnt == `SDL_ACQ_FRAMES - 3'h1)
            begin
                // new word starts a recovered clock cycle
                next_st.word       = st.rx_shreg[9:0];
                next_st.rclk_phase = 4'h0;
            end
        end
        else if (frame_bad)
        begin
            next_st.good_cnt = 3'h0;
            if (st.locked)
            begin
                // four bad frames in a row
                next_st.bad_cnt = st.bad_cnt + 3'h1;
                if (st.bad_cnt == `SDL_LOSS_FRAMES - 3'h1)
                begin
                    next_st.locked  = 1'b0;
                    next_st.bad_cnt = 3'h0;
                    events[`SDL_EV_UNLOCK] = 1'b1;
                end
            end
        end
        // a stalled reference leaves no timebase to trust
        if (!ref_ok && st.locked)
        begin
            next_st.locked = 1'b0;
            events[`SDL_EV_UNLOCK] = 1'b1;
        end

        if (frame_good == 1'b0 && st.rclk_phase != `SDL_RCLK_END)
            next_st.rclk_phase = st.rclk_phase + 4'h1;

        base_high = (next_st.rclk_phase >= `SDL_RCLK_RISE)
                  && (next_st.rclk_phase < `SDL_RCLK_FALL);
        next_st.rclk = recovered_edge_select ? base_high : ~base_high;

        if (!rx_sleep_request_n)
        begin
            next_st.rx_state   = SDL_RX_IDLE;
            next_st.rx_cnt     = 4'h0;
            next_st.rx_wait    = 5'h0;
            next_st.good_cnt   = 3'h0;
            next_st.bad_cnt    = 3'h0;
            next_st.locked     = 1'b0;
            next_st.rclk_phase = `SDL_RCLK_END;
            events[`SDL_EV_UNLOCK] = st.locked;
        end

        // register port; the answer stands for one cycle only
        next_st.rdata = 32'h0;
        if (reg_write && reg_addr == `SDL_ADDR_IRQ_MASK)
            next_st.irq_mask = reg_wdata[2:0];
        next_st.irq_stat = st.irq_stat;
        if (reg_read)
        begin
            unique case (reg_addr)
                `SDL_ADDR_STATUS:
                begin
                    next_st.rdata[`SDL_ST_LOCKED]   = st.locked;
                    next_st.rdata[`SDL_ST_TRAINING] = st.train_act;
                    next_st.rdata[`SDL_ST_TX_SLEEP] = ~tx_sleep_request_n;
                    next_st.rdata[`SDL_ST_RX_SLEEP] = ~rx_sleep_request_n;
                    next_st.rdata[`SDL_ST_REF_OK]   = ref_ok;
                end
                `SDL_ADDR_IRQ_STAT:
                begin
                    next_st.rdata[2:0] = st.irq_stat;
                    next_st.irq_stat   = 3'h0;
                end
                `SDL_ADDR_IRQ_MASK:
                    next_st.rdata[2:0] = st.irq_mask;
                default:
                    next_st.rdata = 32'h0;
            endcase
        end
        // events landing on a clearing read survive it
        next_st.irq_stat = next_st.irq_stat | events;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // each field named once, none written twice on reset
            st.transmit_word_clock_prev  <= 1'b0;
            st.tx_shreg   <= 12'h0;
            st.tx_bits    <= 4'h0;
            st.train_act  <= 1'b0;
            st.train_cnt  <= 11'h0;
            st.rx_state   <= SDL_RX_IDLE;
            st.rx_shreg   <= 11'h0;
            st.rx_cnt     <= 4'h0;
            st.rx_wait    <= 5'h0;
            st.good_cnt   <= 3'h0;
            st.bad_cnt    <= 3'h0;
            st.locked     <= 1'b0;
            st.ref_prev   <= 1'b0;
            st.ref_idle   <= 5'h0;
            st.word       <= 10'h0;
            st.rclk_phase <= `SDL_RCLK_END;
            st.rclk       <= 1'b0;
            st.irq_stat   <= 3'h0;
            st.irq_mask   <= `SDL_IRQ_MASK_RST;
            st.rdata      <= 32'h0;
        end
        else
            st <= next_st;
    end

    // drive enable and sleep float the pair
    assign serial_out_oe  = serial_drive_enable & tx_sleep_request_n;
    assign serial_out_pos = st.tx_shreg[11];
    assign serial_out_neg = ~st.tx_shreg[11];

    assign lock_n  = ~st.locked;
    assign lock_oe = rx_sleep_request_n;

    assign parallel_word_oe   = parallel_output_enable & rx_sleep_request_n
                              & st.locked;
    assign recovered_clock_oe = parallel_word_oe;
    assign parallel_word_out  = st.word;
    assign recovered_clock    = st.rclk;

    assign reg_rdata = st.rdata;
    assign irq       = |(st.irq_stat & st.irq_mask);

endmodule // sdl_link

// ### inc/sdl_regs.svh
// Notes on behaviour
// - latch ten input bits each word clock
// - edge select high rising, low falling
// - drive enable low floats serial outputs
// - sleep low stops logic, floats outputs
// - training request sends at least 1024 symbols
// - held request keeps symbols flowing
// - two training requests are ORed
// - recovered edge select picks strobe edge
// - lock flag low when locked
// - recovered clock strobes each output word
// - output enable low floats word, clock
// - locks after training with reference running
// - not locked floats word and clock
// - four bad frames in row lose lock
// - two clock bits frame each word
`ifndef SDL_REGS_SVH
`define SDL_REGS_SVH

// register word offsets
`define SDL_ADDR_STATUS    8'h00
`define SDL_ADDR_IRQ_STAT  8'h04
`define SDL_ADDR_IRQ_MASK  8'h08

// status fields
`define SDL_ST_LOCKED      0
`define SDL_ST_TRAINING    1
`define SDL_ST_TX_SLEEP    2
`define SDL_ST_RX_SLEEP    3
`define SDL_ST_REF_OK      4

// interrupt event bits
`define SDL_EV_LOCK        0
`define SDL_EV_UNLOCK      1
`define SDL_EV_TRAIN_DONE  2
`define SDL_IRQ_MASK_RST   3'h0

// framing and counts
`define SDL_FRAME_BITS     4'hc
`define SDL_SYNC_WORD      10'h3e0
`define SDL_TRAIN_MIN      11'h400
`define SDL_LOSS_FRAMES    3'h4
`define SDL_ACQ_FRAMES     3'h4
`define SDL_IDLE_LIMIT     5'h18
`define SDL_REF_LIMIT      5'h1f
`define SDL_RCLK_RISE      4'h3
`define SDL_RCLK_FALL      4'h9
`define SDL_RCLK_END       4'hb

`endif

// ### inc/sdl_pkg.sv
package sdl_pkg;

    typedef enum logic [0:0] {
        SDL_RX_IDLE,
        SDL_RX_BITS
    } sdl_rx_e;

    typedef struct packed {
        logic        transmit_word_clock_prev;
        logic [11:0] tx_shreg;
        logic [3:0]  tx_bits;
        logic        train_act;
        logic [10:0] train_cnt;
        sdl_rx_e     rx_state;
        logic [10:0] rx_shreg;
        logic [3:0]  rx_cnt;
        logic [4:0]  rx_wait;
        logic [2:0]  good_cnt;
        logic [2:0]  bad_cnt;
        logic        locked;
        logic        ref_prev;
        logic [4:0]  ref_idle;
        logic [9:0]  word;
        logic [3:0]  rclk_phase;
        logic        rclk;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [31:0] rdata;
    } sdl_state_s;

endpackage

// ### dv/sdl_props.sv
`timescale 1ns/1ns
module sdl_props
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // inputs watched
    input wire logic transmit_word_clock,
    input wire logic transmit_edge_select,
    input wire logic serial_drive_enable,
    input wire logic tx_sleep_request_n,
    input wire logic rx_sleep_request_n,
    input wire logic parallel_output_enable,
    // outputs watched
    input wire logic serial_out_pos,
    input wire logic serial_out_neg,
    input wire logic serial_out_oe,
    input wire logic parallel_word_oe,
    input wire logic recovered_clock_oe,
    input wire logic lock_n,
    input wire logic lock_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_cap_rise;
        tx_sleep_request_n && transmit_edge_select
            && $rose(transmit_word_clock);
    endsequence
    sequence s_cap_fall;
        tx_sleep_request_n && !transmit_edge_select
            && $fell(transmit_word_clock);
    endsequence

    a_rise_start: assert property (s_cap_rise |=> serial_out_pos)
        else $error("no start bit after rising capture");
    a_fall_start: assert property (s_cap_fall |=> serial_out_pos)
        else $error("no start bit after falling capture");
    a_stop_low: assert property ((s_cap_rise or s_cap_fall)
        |-> ##12 !serial_out_pos) else $error("stop bit not low");
    a_line_pair: assert property (serial_out_neg != serial_out_pos)
        else $error("serial pair not complementary");
    a_tx_float: assert property (serial_out_oe ==
        (serial_drive_enable && tx_sleep_request_n))
        else $error("serial enable wrong");
    a_rx_oe_lock: assert property (parallel_word_oe |-> !lock_n
        && rx_sleep_request_n) else $error("word driven while unlocked");
    a_rx_oe_enable: assert property (!parallel_output_enable
        |-> !parallel_word_oe && !recovered_clock_oe)
        else $error("word driven while disabled");
    a_lock_oe: assert property (lock_oe == rx_sleep_request_n)
        else $error("lock flag drive wrong in sleep");
    a_sleep_unlock: assert property (!rx_sleep_request_n
        |-> ##[1:2] lock_n) else $error("lock kept in sleep");
endmodule // sdl_props

bind sdl_link sdl_props u_props (.clk, .reset_n, .transmit_word_clock,
    .transmit_edge_select, .serial_drive_enable, .tx_sleep_request_n,
    .rx_sleep_request_n, .parallel_output_enable, .serial_out_pos,
    .serial_out_neg, .serial_out_oe, .parallel_word_oe,
    .recovered_clock_oe, .lock_n, .lock_oe);

// ### dv/sdl_far_end.sv
`timescale 1ns/1ns
module sdl_far_end
(
    // control from bench
    input  wire logic       clk,
    input  wire logic       send,
    input  wire logic [9:0] word,
    input  wire logic       bad,
    // line toward the receiver
    output logic            line_pos,
    output logic            line_neg,
    output logic            ref_clock
);
    logic [11:0] shreg = '0;
    logic [2:0]  div = '0;

    // start bit, word, stop bit; bad frames carry a high stop
    always @(posedge clk)
    begin
        shreg <= send ? {1'b1, word, bad} : {shreg[10:0], 1'b0};
        div <= div + 3'h1;
    end
    assign line_pos = shreg[11];
    assign line_neg = ~shreg[11];
    // reference runs free, well inside the stall limit
    assign ref_clock = div[2];
endmodule // sdl_far_end

// ### dv/testbench.sv
`timescale 1ns/1ns
`include "sdl_regs.svh"
module testbench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        transmit_word_clock = 1'b0;
    logic        transmit_edge_select = 1'b1;
    logic [9:0]  tx_word_in = '0;
    logic        training_request_a = 1'b0;
    logic        training_request_b = 1'b0;
    logic        serial_drive_enable = 1'b1;
    logic        tx_sleep_request_n = 1'b1;
    logic        recovered_edge_select = 1'b1;
    logic        parallel_output_enable = 1'b1;
    logic        rx_sleep_request_n = 1'b1;
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        send = 1'b0;
    logic        bad = 1'b0;
    logic [9:0]  fw = '0;
    logic        serial_out_pos, serial_out_neg, serial_out_oe;
    logic        serial_in_pos, serial_in_neg, receiver_reference_clock;
    logic [9:0]  parallel_word_out;
    logic        parallel_word_oe, recovered_clock, recovered_clock_oe;
    logic        lock_n, lock_oe, irq;
    logic [31:0] reg_rdata, r;
    integer      n_mismatch = 0;
    integer      n_checks = 0;
    integer      seed = 32'h85ca;
    integer      cyc = 0;
    integer      k;

    sdl_link DUT (.*);
    sdl_far_end u_far (.clk, .send, .word(fw), .bad,
        .line_pos(serial_in_pos), .line_neg(serial_in_neg),
        .ref_clock(receiver_reference_clock));

    always #4 clk = ~clk;

    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // longest run is the two training bursts, about 32k cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 50000)
        begin
            n_mismatch++;
            stop_test;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [11:0] frame(input logic [9:0] d);
        frame = {1'b1, d, 1'b0};
    endfunction

    task automatic tx_word(input logic [9:0] d, input logic [9:0] e);
        logic [11:0] f;
        f = frame(e);
        @(posedge clk);
        tx_word_in <= d;
        transmit_word_clock <= ~transmit_edge_select;
        @(posedge clk);
        transmit_word_clock <= transmit_edge_select;
        @(posedge clk);
        // new data right after capture proves the word was latched
        tx_word_in <= 10'($random(seed));
        for (int i = 0; i < 12; i++)
        begin
            #1 check(serial_out_pos, f[11-i]);
            @(posedge clk);
        end
    endtask

    task automatic tx_rand(input logic train);
        logic [31:0] v;
        v = $random(seed);
        tx_word(v[9:0], train ? `SDL_SYNC_WORD : v[9:0]);
    endtask

    task automatic rx_frame(input logic [9:0] d, input logic b,
                            input logic el);
        fw <= d;
        bad <= b;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (14) @(posedge clk);
        #1 check(lock_n, el);
        @(posedge clk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, e);
        @(posedge clk);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        r = $random(seed);
        recovered_edge_select <= r[0];
        @(posedge clk);
        for (k = 0; k < 16; k++)
        begin
            transmit_edge_select <= k[0];
            tx_rand(1'b0);
        end
        $display("capture test done");
        // one-cycle pulse on the second request
        training_request_b <= 1'b1;
        @(posedge clk);
        training_request_b <= 1'b0;
        for (k = 0; k < `SDL_TRAIN_MIN; k++)
            tx_rand(1'b1);
        tx_rand(1'b0);
        // held request keeps the burst going past the minimum
        training_request_a <= 1'b1;
        for (k = 0; k < 1100; k++)
            tx_rand(1'b1);
        training_request_a <= 1'b0;
        tx_rand(1'b0);
        $display("training test done");
        // training words first, then one data word
        for (k = 0; k < 3; k++)
            rx_frame(`SDL_SYNC_WORD, 1'b0, 1'b1);
        r = $random(seed);
        rx_frame(r[9:0], 1'b0, 1'b0);
        #1 check(parallel_word_out, r[9:0]);
        check(recovered_clock_oe, 1'b1);
        check(recovered_clock, recovered_edge_select);
        recovered_edge_select <= ~recovered_edge_select;
        @(posedge clk);
        parallel_output_enable <= 1'b0;
        #1 check(parallel_word_oe, 1'b0);
        check(recovered_clock, recovered_edge_select);
        @(posedge clk);
        parallel_output_enable <= 1'b1;
        for (k = 0; k < 4; k++)
            rx_frame(`SDL_SYNC_WORD, 1'b1, k == 3);
        #1 check(parallel_word_oe, 1'b0);
        @(posedge clk);
        $display("receive test done");
        reg_wr(`SDL_ADDR_STATUS, '1);
        reg_rd(`SDL_ADDR_STATUS, 32'h10);
        reg_rd(`SDL_ADDR_IRQ_MASK, 32'h0);
        #1 check(irq, 1'b0);
        reg_wr(`SDL_ADDR_IRQ_MASK, 32'h7);
        #1 check(irq, 1'b1);
        @(posedge clk);
        reg_rd(`SDL_ADDR_IRQ_STAT, 32'h7);
        #1 check(irq, 1'b0);
        reg_rd(`SDL_ADDR_IRQ_STAT, 32'h0);
        reg_rd(8'h10, 32'h0);
        $display("register test done");
        // relock first so that sleep has a lock to drop
        for (k = 0; k < 4; k++)
            rx_frame(`SDL_SYNC_WORD, 1'b0, k != 3);
        rx_sleep_request_n <= 1'b0;
        tx_sleep_request_n <= 1'b0;
        #1 check(serial_out_oe, 1'b0);
        check(lock_oe, 1'b0);
        check(parallel_word_oe, 1'b0);
        @(posedge clk);
        reg_rd(`SDL_ADDR_STATUS, 32'h1c);
        #1 check(lock_n, 1'b1);
        tx_sleep_request_n <= 1'b1;
        serial_drive_enable <= 1'b0;
        #1 check(serial_out_oe, 1'b0);
        $display("sleep test done");
        stop_test;
    end
endmodule // testbench
